// ==== ers_model.sv ====
// External reset/trigger source model
`timescale 1ns/10ps
module ers_model (
  // Clock
  input wire logic clock,
  // Requested pin level
  input wire logic level_req,
  // Pin
  output logic external_reset_trigger_in
);
  initial external_reset_trigger_in = 1'b0;
  // Pin follows the request at the next rising edge, never racing the bench
  always @(posedge clock) external_reset_trigger_in <= level_req;
endmodule : ers_model

// ==== hw_limit_timer.sv ====
// Mode control and counter of the 8-bit hardware limit period timer
//
// Functional notes
// [RULE1] Software gate: count while run, else hold
// [RULE2] Free-running: wrap to zero after period match
// [RULE3] Hardware gate adds external input gating
// [RULE4] Active-high gate counts while input high
// [RULE5] Active-low gate counts while input low
// [RULE6] Edge-reset modes clear count on edge
// [RULE7] Level-reset modes hold count cleared
// [RULE8] Level-reset ignores input while run clear
// [RULE9] Level reset acts and releases two ticks later
// [RULE10] Software one shot: match clears count, run
// [RULE11] Run pause resumes same one-shot count
// [RULE12] Software restarts one shot by setting run
// [RULE13] Edge-start one shot: edge starts, match stops
// [RULE14] After run cleared, need fresh edge
// [RULE15] First edge starts, later edges clear count
// [RULE16] Restart two ticks after each reset edge
// [RULE17] Edges ignored until run; match clears run
// [RULE18] Level reset holds, active transition starts
// [RULE19] Restart needs new edge after run set
// [RULE20] Instruction clock: one period sync delay
// [RULE21] Other clocks: two tick sync delay
// [RULE22] Run clear resets all state machines
// [RULE23] Eight-bit count, equality period compare
`timescale 1ns/10ps
module hw_limit_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Timer clock enable and its kind
  input wire logic timer_tick,
  input wire logic instr_clock_sel,
  // Software run bit write
  input wire logic run_write,
  input wire logic run_wdata,
  // Configuration
  input wire logic [timer_pkg::MODE_W-1:0] mode_select,
  input wire logic [timer_pkg::COUNT_W-1:0] period_value,
  // External reset or trigger pin
  input wire logic external_reset_trigger_in,
  // Status
  output logic run_bit,
  output logic [timer_pkg::COUNT_W-1:0] count_value,
  output logic period_match,
  output logic counting
);
  import timer_pkg::*;

  // ==========================================================
  // Declarations
  seq_state_t state;
  seq_state_t next_state;
  logic [COUNT_W-1:0] next_count;
  logic next_match;
  logic next_counting;
  logic clear_run;
  logic active;
  logic match;
  logic delay_req;
  logic delay_done;
  qual_if q ();

  // ==========================================================
  // Decoding helpers

  // Gate condition of the gated free-running modes
  function automatic logic gate_open(input logic [MODE_W-1:0] m, input logic lvl);
    logic r;
    r = 1'b0;
    case (m)
      MODE_SW_GATE: r = 1'b1;
      MODE_GATE_HIGH: r = lvl;
      MODE_GATE_LOW: r = ~lvl;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : gate_open

  // Qualifying edge of the edge driven modes
  function automatic logic edge_hit(input logic [MODE_W-1:0] m, input logic rise,
                                    input logic fall);
    logic r;
    r = 1'b0;
    case (m)
      MODE_RST_ANY: r = rise | fall;
      MODE_RST_RISE: r = rise;
      MODE_RST_FALL: r = fall;
      MODE_OS_RISE: r = rise;
      MODE_OS_FALL: r = fall;
      MODE_OS_ANY: r = rise | fall;
      MODE_OS_ER_RISE: r = rise;
      MODE_OS_ER_FALL: r = fall;
      MODE_OS_LR_LOW: r = rise;
      MODE_OS_LR_HIGH: r = fall;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : edge_hit

  // External input at the selected reset level
  function automatic logic at_reset_level(input logic [MODE_W-1:0] m, input logic lvl);
    logic r;
    r = 1'b0;
    case (m)
      MODE_RST_LOW: r = ~lvl;
      MODE_RST_HIGH: r = lvl;
      MODE_OS_LR_LOW: r = ~lvl;
      MODE_OS_LR_HIGH: r = lvl;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : at_reset_level

  // Incremented count, cut to the counter width
  function automatic logic [COUNT_W-1:0] bump(input logic [COUNT_W-1:0] c);
    logic [COUNT_W:0] s;
    s = {1'b0, c} + {{COUNT_W{1'b0}}, 1'b1};
    return s[COUNT_W-1:0];
  endfunction : bump

  // ==========================================================
  // Input qualification
  input_qualifier u_qual (
    .clock(clock),
    .sys_rst(sys_rst),
    .timer_tick(timer_tick),
    .instr_clock_sel(instr_clock_sel),
    .run_bit(run_bit),
    .external_reset_trigger_in(external_reset_trigger_in),
    .q(q)
  );

  // Hardware run clear takes effect at once, not after the sync delay
  assign active = run_bit & q.run_q; // RULE20 RULE21
  assign match = (count_value == period_value); // RULE23

  // ==========================================================
  // Two tick restart delay
  always_comb begin
    delay_req = 1'b0;
    case (mode_select)
      MODE_RST_LOW, MODE_RST_HIGH: begin
        delay_req = at_reset_level(mode_select, q.ers_level); // RULE9
      end
      MODE_OS_ER_RISE, MODE_OS_ER_FALL: begin
        delay_req = (state == ST_RUN || state == ST_HOLD) &&
                    edge_hit(mode_select, q.ers_rise, q.ers_fall); // RULE16
      end
      default: begin
        delay_req = 1'b0;
      end
    endcase
  end

  restart_delay u_delay (
    .clock(clock),
    .sys_rst(sys_rst),
    .timer_tick(timer_tick),
    .flush(~active), // RULE8
    .req(delay_req),
    .done(delay_done)
  );

  // ==========================================================
  // Next count and sequencer state
  always_comb begin
    next_count = count_value;
    next_state = state;
    next_match = 1'b0;
    next_counting = 1'b0;
    clear_run = 1'b0;
    if (!active) begin
      // Count holds so a paused cycle resumes
      next_state = ST_WAIT; // RULE22 RULE11 RULE14 RULE19
    end else if (timer_tick) begin
      case (mode_select)
        MODE_SW_GATE, MODE_GATE_HIGH, MODE_GATE_LOW: begin
          if (gate_open(mode_select, q.ers_level)) begin // RULE1 RULE3 RULE4 RULE5
            next_counting = 1'b1;
            if (match) begin
              next_count = COUNT_RESET; // RULE2
              next_match = 1'b1;
            end else begin
              next_count = bump(count_value);
            end
          end
        end
        MODE_RST_ANY, MODE_RST_RISE, MODE_RST_FALL: begin
          next_counting = 1'b1;
          if (edge_hit(mode_select, q.ers_rise, q.ers_fall)) begin
            next_count = COUNT_RESET; // RULE6
          end else if (match) begin
            next_count = COUNT_RESET; // RULE2
            next_match = 1'b1;
          end else begin
            next_count = bump(count_value);
          end
        end
        MODE_RST_LOW, MODE_RST_HIGH: begin
          if (delay_done) begin
            next_count = COUNT_RESET; // RULE7 RULE9
          end else if (match) begin
            next_counting = 1'b1;
            next_count = COUNT_RESET; // RULE2
            next_match = 1'b1;
          end else begin
            next_counting = 1'b1;
            next_count = bump(count_value);
          end
        end
        MODE_OS_SW: begin
          next_counting = 1'b1;
          if (match) begin
            next_count = COUNT_RESET; // RULE10
            next_match = 1'b1;
            clear_run = 1'b1; // RULE10 RULE12
          end else begin
            next_count = bump(count_value);
          end
        end
        MODE_OS_RISE, MODE_OS_FALL, MODE_OS_ANY: begin
          case (state)
            ST_WAIT: begin
              if (edge_hit(mode_select, q.ers_rise, q.ers_fall)) begin
                next_state = ST_RUN; // RULE13
              end
            end
            ST_RUN: begin
              next_counting = 1'b1;
              if (match) begin
                next_count = COUNT_RESET;
                next_match = 1'b1;
                clear_run = 1'b1; // RULE13
                next_state = ST_WAIT;
              end else begin
                next_count = bump(count_value);
              end
            end
            default: begin
              next_state = ST_WAIT;
            end
          endcase
        end
        MODE_OS_ER_RISE, MODE_OS_ER_FALL: begin
          case (state)
            ST_WAIT: begin
              if (edge_hit(mode_select, q.ers_rise, q.ers_fall)) begin
                next_state = ST_RUN; // RULE15 RULE17
              end
            end
            ST_RUN: begin
              if (edge_hit(mode_select, q.ers_rise, q.ers_fall)) begin
                next_count = COUNT_RESET; // RULE15
                next_state = ST_HOLD;
              end else if (match) begin
                next_counting = 1'b1;
                next_count = COUNT_RESET;
                next_match = 1'b1;
                clear_run = 1'b1; // RULE17
                next_state = ST_WAIT;
              end else begin
                next_counting = 1'b1;
                next_count = bump(count_value);
              end
            end
            ST_HOLD: begin
              next_count = COUNT_RESET;
              if (delay_done && !delay_req) begin
                next_state = ST_RUN; // RULE16
              end
            end
            default: begin
              next_state = ST_WAIT;
            end
          endcase
        end
        MODE_OS_LR_LOW, MODE_OS_LR_HIGH: begin
          case (state)
            ST_WAIT: begin
              if (at_reset_level(mode_select, q.ers_level)) begin
                next_count = COUNT_RESET; // RULE18
              end
              if (edge_hit(mode_select, q.ers_rise, q.ers_fall)) begin
                next_state = ST_RUN; // RULE18 RULE19
              end
            end
            ST_RUN: begin
              if (at_reset_level(mode_select, q.ers_level)) begin
                next_count = COUNT_RESET; // RULE18
                next_state = ST_WAIT;
              end else if (match) begin
                next_counting = 1'b1;
                next_count = COUNT_RESET;
                next_match = 1'b1;
                clear_run = 1'b1; // RULE19
                next_state = ST_WAIT;
              end else begin
                next_counting = 1'b1;
                next_count = bump(count_value);
              end
            end
            default: begin
              next_state = ST_WAIT;
            end
          endcase
        end
        default: begin
          next_count = count_value;
        end
      endcase
    end
  end

  // ==========================================================
  // Counter
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count_value <= COUNT_RESET;
    end else begin
      count_value <= next_count;
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Run bit, software write wins over the hardware clear
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      run_bit <= RUN_RESET;
    end else if (run_write) begin
      run_bit <= run_wdata;
    end else if (clear_run) begin
      run_bit <= 1'b0; // RULE10 RULE13 RULE17
    end
  end

  // ==========================================================
  // Status flags
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      period_match <= 1'b0;
    end else begin
      period_match <= next_match;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      counting <= 1'b0;
    end else if (!active) begin
      counting <= 1'b0;
    end else if (timer_tick) begin
      counting <= next_counting;
    end
  end
endmodule : hw_limit_timer

// ==== hw_limit_timer_asserts.sv ====
// Concurrent checks on the hardware limit timer ports
`timescale 1ns/10ps
module hw_limit_timer_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Inputs
  input wire logic timer_tick,
  input wire logic run_write,
  input wire logic run_wdata,
  input wire logic [timer_pkg::MODE_W-1:0] mode_select,
  input wire logic [timer_pkg::COUNT_W-1:0] period_value,
  // Outputs
  input wire logic run_bit,
  input wire logic [timer_pkg::COUNT_W-1:0] count_value,
  input wire logic period_match,
  input wire logic counting
);
  import timer_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Counter
  no_tick_hold_a: assert property (!timer_tick |=> $stable(count_value))
    else $error("count moved without a tick");
  stop_hold_a: assert property (!run_bit && timer_tick |=> $stable(count_value) && !counting)
    else $error("count moved while stopped");
  step_one_a: assert property (counting && $past(timer_tick) |->
    count_value == $past(count_value) + 8'h01 || count_value == 8'h00)
    else $error("count step not one");
  match_clear_a: assert property (period_match |-> count_value == 8'h00)
    else $error("count not zero after match");
  match_cause_a: assert property (period_match |->
    $past(count_value) == $past(period_value))
    else $error("match without equal count");
  // ==========================================================
  // Run bit
  oneshot_stop_a: assert property (period_match && mode_select[4:3] == 2'b01
    && !$past(run_write) |-> !run_bit)
    else $error("one shot kept run after match");
  free_keep_a: assert property (period_match && mode_select[4:3] == 2'b00
    && !$past(run_write) |-> run_bit)
    else $error("free run lost run at match");
  write_apply_a: assert property (run_write |=> run_bit == $past(run_wdata))
    else $error("run write not applied");
  run_set_sw_a: assert property ($rose(run_bit) |-> $past(run_write))
    else $error("run set without write");
endmodule : hw_limit_timer_asserts

bind hw_limit_timer hw_limit_timer_asserts hw_limit_timer_asserts_inst (
  .clock(clock), .sys_rst(sys_rst), .timer_tick(timer_tick), .run_write(run_write),
  .run_wdata(run_wdata), .mode_select(mode_select), .period_value(period_value),
  .run_bit(run_bit), .count_value(count_value), .period_match(period_match),
  .counting(counting));

// ==== input_qualifier.sv ====
// Pin synchroniser and timer clock sync delay for run and external input
`timescale 1ns/10ps
module input_qualifier (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Timer clock enable and sync selection
  input wire logic timer_tick,
  input wire logic instr_clock_sel,
  // Raw inputs
  input wire logic run_bit,
  input wire logic external_reset_trigger_in,
  // Qualified outputs
  qual_if.source q
);
  import timer_pkg::*;

  logic pin_meta;
  logic pin_sync;
  logic [1:0] stage [SYNC_TICKS_OTHER];
  logic [1:0] picked;
  logic [1:0] prev_seen;

  // ==========================================================
  // Two flop pin synchroniser
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= external_reset_trigger_in;
      pin_sync <= pin_meta;
    end
  end

  // ==========================================================
  // Timer clock delay stages, bit 1 run, bit 0 external
  genvar i;
  generate
    for (i = 0; i < SYNC_TICKS_OTHER; i++) begin : g_stage
      if (i == 0) begin : g_first
        always_ff @(posedge clock or posedge sys_rst) begin
          if (sys_rst) begin
            stage[i] <= 2'h0;
          end else if (timer_tick) begin
            stage[i] <= {run_bit, pin_sync};
          end
        end
      end else begin : g_next
        always_ff @(posedge clock or posedge sys_rst) begin
          if (sys_rst) begin
            stage[i] <= 2'h0;
          end else if (timer_tick) begin
            stage[i] <= stage[i-1];
          end
        end
      end
    end
  endgenerate

  assign picked = instr_clock_sel ? stage[SYNC_TICKS_INSTR-1] : stage[SYNC_TICKS_OTHER-1]; // RULE20 RULE21

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prev_seen <= 2'h0;
    end else if (timer_tick) begin
      prev_seen <= picked;
    end
  end

  // Edges need run seen one tick earlier, so the first level after reset is no edge
  assign q.ers_level = picked[0];
  assign q.run_q = picked[1];
  assign q.ers_rise = timer_tick & prev_seen[1] & picked[0] & ~prev_seen[0];
  assign q.ers_fall = timer_tick & prev_seen[1] & ~picked[0] & prev_seen[0];
endmodule : input_qualifier

// ==== qual_if.sv ====
// Qualified external input and run level, timer clock aligned
`timescale 1ns/10ps
interface qual_if;
  logic ers_level;
  logic ers_rise;
  logic ers_fall;
  logic run_q;
  modport source (output ers_level, output ers_rise, output ers_fall, output run_q);
  modport sink (input ers_level, input ers_rise, input ers_fall, input run_q);
endinterface : qual_if

// ==== restart_delay.sv ====
// Delays a request by a fixed number of timer clock ticks
`timescale 1ns/10ps
module restart_delay (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Timing
  input wire logic timer_tick,
  input wire logic flush,
  // Request and delayed copy
  input wire logic req,
  output logic done
);
  import timer_pkg::*;

  logic [RESTART_TICKS-1:0] pipe;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pipe <= '0;
    end else if (flush) begin
      pipe <= '0;
    end else if (timer_tick) begin
      pipe <= {pipe[RESTART_TICKS-2:0], req};
    end
  end

  assign done = pipe[RESTART_TICKS-1];
endmodule : restart_delay

// ==== test_hw_limit_timer.sv ====
// Self-checking bench for the hardware limit timer
`timescale 1ns/10ps
module test_hw_limit_timer;
  import timer_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic timer_tick = 1'b0;
  logic instr_clock_sel = 1'b0;
  logic run_write = 1'b0;
  logic run_wdata = 1'b0;
  logic ers_req = 1'b0;
  logic [MODE_W-1:0] mode_select = 5'h00;
  logic [COUNT_W-1:0] period_value = 8'hff;
  logic external_reset_trigger_in, run_bit, period_match, counting;
  logic [COUNT_W-1:0] count_value;
  int bad_count = 0;
  int cmp_count = 0;
  localparam logic [MODE_W-1:0] OS_MODES [5] = '{MODE_OS_RISE, MODE_OS_FALL, MODE_OS_ANY,
    MODE_OS_LR_LOW, MODE_OS_LR_HIGH};

  always #10 clock = ~clock;
  always @(negedge clock) timer_tick <= ~timer_tick;

  ers_model ers_model_inst (.clock(clock), .level_req(ers_req),
    .external_reset_trigger_in(external_reset_trigger_in));
  hw_limit_timer hw_limit_timer_inst (.clock(clock), .sys_rst(sys_rst),
    .timer_tick(timer_tick), .instr_clock_sel(instr_clock_sel), .run_write(run_write),
    .run_wdata(run_wdata), .mode_select(mode_select), .period_value(period_value),
    .external_reset_trigger_in(external_reset_trigger_in), .run_bit(run_bit),
    .count_value(count_value), .period_match(period_match), .counting(counting));

  // ==========================================================
  // Helpers
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task tk(input int k);
    repeat (k) @(negedge clock);
  endtask : tk
  task wr(input logic v);
    run_write = 1'b1;
    run_wdata = v;
    tk(1);
    run_write = 1'b0;
  endtask : wr
  task setup(input logic [MODE_W-1:0] m, input logic [COUNT_W-1:0] p, input logic l);
    sys_rst = 1'b1;
    mode_select = m;
    period_value = p;
    ers_req = l;
    instr_clock_sel = 1'($urandom_range(1, 0));
    tk(2);
    sys_rst = 1'b0;
    tk(1);
  endtask : setup
  task wm(input int lim);
    int k;
    k = 0;
    while (period_match !== 1'b1 && k < lim) begin
      tk(1);
      k++;
    end
    if (period_match !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: no period match within %h", $time, lim);
      finish_test();
    end
  endtask : wm

  // ==========================================================
  // Scenarios
  initial begin
    logic [COUNT_W-1:0] p, c0;
    logic s;
    int n;
    void'($urandom(32'h58847df3));
    for (int i = 0; i < 2; i++) begin
      setup(MODE_SW_GATE, 8'hff, 1'b0);
      instr_clock_sel = i[0];
      wr(1'b1);
      n = 0;
      for (int k = 0; k < 60 && count_value === 8'h00; k++) begin
        if (timer_tick && run_bit) n++;
        tk(1);
      end
      check(n, i ? SYNC_TICKS_INSTR + 1 : SYNC_TICKS_OTHER + 1);
    end
    p = 8'($urandom_range(9, 2));
    setup(MODE_SW_GATE, p, 1'b0);
    wr(1'b1);
    wm(100);
    check(count_value, 8'h00);
    n = 0;
    for (int k = 0; k < 6 * (p + 1); k++) begin
      tk(1);
      if (period_match === 1'b1) n++;
    end
    check(n, 3);
    check(run_bit, 1'b1);
    wr(1'b0);
    c0 = count_value;
    tk(20);
    check(count_value, c0);
    check(counting, 1'b0);
    for (int g = 0; g < 2; g++) begin
      setup(g ? MODE_GATE_LOW : MODE_GATE_HIGH, 8'hff, g[0]);
      wr(1'b1);
      tk(30);
      check(count_value, 8'h00);
      check(counting, 1'b0);
      ers_req = !g[0];
      tk(30);
      check(count_value != 8'h00, 1'b1);
      check(counting, 1'b1);
      ers_req = g[0];
      tk(14);
      c0 = count_value;
      tk(20);
      check(count_value, c0);
    end
    for (int i = 0; i < 3; i++) begin
      s = (i == 1);
      setup(MODE_RST_ANY + 5'(i), 8'hff, s);
      wr(1'b1);
      for (int e = 0; e < 2; e++) begin
        tk(40);
        c0 = count_value;
        ers_req = (e == 0) ? !s : s;
        tk(16);
        check(count_value < c0, e == 1 || i == 0);
      end
    end
    for (int i = 0; i < 2; i++) begin
      s = i[0];
      setup(MODE_RST_LOW + 5'(i), 8'hff, !s);
      wr(1'b1);
      tk(40);
      ers_req = s;
      tk(16);
      check(count_value, 8'h00);
      tk(30);
      check(count_value, 8'h00);
      ers_req = !s;
      tk(16);
      check(count_value != 8'h00, 1'b1);
      wr(1'b0);
      c0 = count_value;
      ers_req = s;
      tk(20);
      check(count_value, c0);
    end
    p = 8'($urandom_range(12, 4));
    setup(MODE_OS_SW, p, 1'b0);
    wr(1'b1);
    for (int k = 0; k < 60 && count_value < 8'h02; k++) tk(1);
    wr(1'b0);
    c0 = count_value;
    tk(20);
    check(count_value, c0);
    wr(1'b1);
    wm(100);
    check(run_bit, 1'b0);
    tk(20);
    check(count_value, 8'h00);
    wr(1'b1);
    wm(100);
    check(run_bit, 1'b0);
    for (int i = 0; i < 5; i++) begin
      s = (OS_MODES[i] == MODE_OS_FALL || OS_MODES[i] == MODE_OS_LR_HIGH);
      setup(OS_MODES[i], 8'($urandom_range(9, 2)), s);
      wr(1'b1);
      tk(30);
      check(count_value, 8'h00);
      ers_req = !s;
      wm(100);
      check(run_bit, 1'b0);
      wr(1'b1);
      tk(30);
      check(count_value, 8'h00);
    end
    for (int i = 0; i < 2; i++) begin
      s = i[0];
      setup(MODE_OS_ER_RISE + 5'(i), 8'hff, s);
      ers_req = !s;
      tk(12);
      ers_req = s;
      tk(12);
      check(count_value, 8'h00);
      wr(1'b1);
      tk(10);
      ers_req = !s;
      tk(60);
      c0 = count_value;
      ers_req = s;
      tk(12);
      ers_req = !s;
      tk(20);
      check(count_value < c0 && count_value != 8'h00, 1'b1);
      wm(600);
      check(run_bit, 1'b0);
    end
    finish_test();
  end
endmodule : test_hw_limit_timer

// ==== timer_pkg.sv ====
// Shared constants for the hardware limit period timer
package timer_pkg;
  // ==========================================================
  // Widths
  localparam int COUNT_W = 8;
  localparam int MODE_W = 5;

  // ==========================================================
  // Reset values
  localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
  localparam logic RUN_RESET = 1'b0;

  // ==========================================================
  // Timing counts, in timer clock ticks
  localparam int SYNC_TICKS_INSTR = 1;
  localparam int SYNC_TICKS_OTHER = 2;
  localparam int RESTART_TICKS = 2;

  // ==========================================================
  // Mode codes
  localparam logic [MODE_W-1:0] MODE_SW_GATE = 5'h00;
  localparam logic [MODE_W-1:0] MODE_GATE_HIGH = 5'h01;
  localparam logic [MODE_W-1:0] MODE_GATE_LOW = 5'h02;
  localparam logic [MODE_W-1:0] MODE_RST_ANY = 5'h03;
  localparam logic [MODE_W-1:0] MODE_RST_RISE = 5'h04;
  localparam logic [MODE_W-1:0] MODE_RST_FALL = 5'h05;
  localparam logic [MODE_W-1:0] MODE_RST_LOW = 5'h06;
  localparam logic [MODE_W-1:0] MODE_RST_HIGH = 5'h07;
  localparam logic [MODE_W-1:0] MODE_OS_SW = 5'h08;
  localparam logic [MODE_W-1:0] MODE_OS_RISE = 5'h09;
  localparam logic [MODE_W-1:0] MODE_OS_FALL = 5'h0a;
  localparam logic [MODE_W-1:0] MODE_OS_ANY = 5'h0b;
  localparam logic [MODE_W-1:0] MODE_OS_ER_RISE = 5'h0c;
  localparam logic [MODE_W-1:0] MODE_OS_ER_FALL = 5'h0d;
  localparam logic [MODE_W-1:0] MODE_OS_LR_LOW = 5'h0e;
  localparam logic [MODE_W-1:0] MODE_OS_LR_HIGH = 5'h0f;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_RUN = 3'b010,
    ST_HOLD = 3'b100
  } seq_state_t;
endpackage : timer_pkg
